// *** logic/tsd_status_map.vh ***
`ifndef TSD_STATUS_MAP_VH
`define TSD_STATUS_MAP_VH

// ****************************************
// register numbers (status index)
// ****************************************
`define TSD_REG_BOOT_STATUS    8'h03
`define TSD_REG_SECURITY_COPY  8'h05
`define TSD_REG_OSC_CONTROL    8'h06
`define TSD_REG_OSC_COUNT_BASE 8'h07
`define TSD_REG_OSC_COUNT_LAST 8'h0A
`define TSD_REG_SAVED_STATUS   8'h10
`define TSD_REG_SAVED_PC       8'h11
`define TSD_REG_SAVED_SP       8'h12
`define TSD_REG_READ_CORE_SEL  8'h13
`define TSD_REG_READ_REG_SEL   8'h14
`define TSD_REG_ENTRY_CAUSE    8'h15
`define TSD_REG_ENTRY_DATA     8'h16
`define TSD_REG_CORE_STOP_MASK 8'h18
`define TSD_REG_MAILBOX_BASE   8'h20
`define TSD_REG_MAILBOX_LAST   8'h27
`define TSD_REG_IBREAK_BASE    8'h30
`define TSD_REG_IBREAK_LAST    8'h33

// ****************************************
// field positions
// ****************************************
`define TSD_BOOT_TILE_NUM_LSB  16
`define TSD_BOOT_OTP_EN_BIT    8
`define TSD_OSC_TILE_RUN_BIT   1
`define TSD_OSC_PERIPH_RUN_BIT 0
`define TSD_CAUSE_INDEX_LSB    16
`define TSD_CAUSE_CORE_LSB     8

// ****************************************
// reset values and cause codes
// ****************************************
`define TSD_OSC_CONTROL_RST    2'h0
`define TSD_CAUSE_RST          3'h0
`define TSD_CAUSE_HOST_JTAG    3'h1
`define TSD_CAUSE_DEBUG_CALL   3'h2
`define TSD_CAUSE_IBREAK       3'h3
`define TSD_CAUSE_DATA_WATCH   3'h4
`define TSD_CAUSE_RES_WATCH    3'h5

`endif

// *** logic/tsd_status_regs.v ***
// Notes on behaviour
// - boot status bits 23:16 read the tile number on the switch
// - boot status bit 8 reads 1 when one-time-memory boot is enabled
// - boot status low byte shows the sampled boot select pins
// - security register reads the security word loaded from one-time memory
// - four free-running oscillators each advance a counter, started by control
// - control bit 1, reset 0, runs both tile oscillators
// - control bit 0, reset 0, runs both peripheral oscillators
// - four count registers give 16 bits, top half zero, kept over reset
// - oscillators run unrelated to the tile clock, usable as random bits
// - debug entry captures saved status, program counter and stack pointer
// - first read operand holds the logical core number in its low byte
// - second read operand holds a 5-bit core register number
// - 3-bit cause, reset 0: jtag, call, ibreak, data watch, resource watch
// - breakpoint or watchpoint index recorded, lowest index wins
// - core number field holds the causing core, else zero
// - entry data captures watch address or resource identifier
// - 8-bit mask stops set cores outside debug mode
// - eight 32-bit mailbox words shared with the external debugger
// - four breakpoint addresses each flag a hit on program counter match
`timescale 1ns/1ns
`include "tsd_status_map.vh"

module tsd_status_regs #(
	parameter CORES     = 8,
	parameter OSC_WIDTH = 16
) (
	// clock and reset
	input  wire        sys_clk,
	input  wire        arst_n,
	// status register access from the core
	input  wire        ps_rd,
	input  wire        ps_wr,
	input  wire [7:0]  ps_addr,
	input  wire [31:0] ps_wdata,
	output reg  [31:0] ps_rdata_q,
	output reg         ps_rvalid_q,
	// boot and security sources
	input  wire [7:0]  tile_number,
	input  wire        otp_boot_en,
	input  wire [7:0]  boot_select_pins,
	input  wire [31:0] security_word,
	// ring oscillators
	input  wire [3:0]  ring_osc_tick,
	output reg  [1:0]  ring_osc_run_q,
	// debug entry from the core
	input  wire        debug_mode,
	input  wire        dbg_entry,
	input  wire [2:0]  dbg_entry_cause,
	input  wire [3:0]  dbg_entry_hits,
	input  wire        dbg_entry_core_valid,
	input  wire [7:0]  dbg_entry_core,
	input  wire [31:0] dbg_entry_data,
	input  wire [31:0] saved_status_word,
	input  wire [31:0] saved_program_counter,
	input  wire [31:0] saved_stack_pointer,
	// core control and breakpoints
	output reg  [7:0]  core_stop_mask_q,
	input  wire        pc_valid,
	input  wire [31:0] pc_value,
	output reg  [3:0]  ibreak_hit_q
);

	// ****************************************
	// state
	// ****************************************
	// synchroniser stages
	reg  [7:0]           boot_meta_q;
	reg  [7:0]           boot_sync_q;
	reg  [3:0]           tick_meta_q;
	reg  [3:0]           tick_sync_q;
	reg  [3:0]           tick_last_q;
	// oscillator counts, deliberately without reset
	reg  [OSC_WIDTH-1:0] osc_count_q [0:3];
	// state captured on debug entry or written by the debugger
	reg  [31:0]          saved_status_q;
	reg  [31:0]          saved_pc_q;
	reg  [31:0]          saved_sp_q;
	reg  [7:0]           read_core_sel_q;
	reg  [4:0]           read_reg_sel_q;
	reg  [2:0]           cause_q;
	reg  [1:0]           cause_index_q;
	reg  [7:0]           cause_core_q;
	reg  [31:0]          entry_data_q;
	// storage shared with the external debugger
	reg  [31:0]          mailbox_q [0:7];
	reg  [31:0]          ibreak_addr_q [0:3];
	// read path and write qualifier
	reg  [31:0]          rdata_d;
	wire                 dbg_wr;
	wire [3:0]           osc_run;
	integer              i;

	// writes to debug fields only count while the core is in debug mode
	assign dbg_wr  = ps_wr & debug_mode;
	// tile oscillators sit on ticks 0 and 1, peripheral ones on ticks 2 and 3
	assign osc_run[0] = ring_osc_run_q[`TSD_OSC_TILE_RUN_BIT];
	assign osc_run[1] = ring_osc_run_q[`TSD_OSC_TILE_RUN_BIT];
	assign osc_run[2] = ring_osc_run_q[`TSD_OSC_PERIPH_RUN_BIT];
	assign osc_run[3] = ring_osc_run_q[`TSD_OSC_PERIPH_RUN_BIT];

	// ****************************************
	// helpers
	// ****************************************
	// lowest set hit bit; several triggers at once keep the smallest index
	function [1:0] lowest_hit;
		input [3:0] hits;
		begin
			if (hits[0]) begin
				lowest_hit = 2'h0;
			end else if (hits[1]) begin
				lowest_hit = 2'h1;
			end else if (hits[2]) begin
				lowest_hit = 2'h2;
			end else if (hits[3]) begin
				lowest_hit = 2'h3;
			end else begin
				// no hit at all reads as index 0
				lowest_hit = 2'h0;
			end
		end
	endfunction

	// true when addr falls in an inclusive window of register numbers
	function in_range;
		input [7:0] addr;
		input [7:0] lo;
		input [7:0] hi;
		begin
			in_range = (addr >= lo) && (addr <= hi);
		end
	endfunction

	// ****************************************
	// pin synchronisers
	// ****************************************
	// boot pins and oscillator ticks come from outside the tile clock
	// only the later stages feed logic; the first may settle late
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			boot_meta_q <= 8'h00;
			boot_sync_q <= 8'h00;
			tick_meta_q <= 4'h0;
			tick_sync_q <= 4'h0;
			tick_last_q <= 4'h0;
		end else begin
			boot_meta_q <= boot_select_pins;
			boot_sync_q <= boot_meta_q;
			tick_meta_q <= ring_osc_tick;
			tick_sync_q <= tick_meta_q;
			tick_last_q <= tick_sync_q;
		end
	end

	// ****************************************
	// ring oscillator counters
	// ****************************************
	// no reset on purpose so the count survives a system reset; the tick is
	// sampled, so an oscillator faster than half the tile clock loses edges
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : osc_cnt
			// tick g counts only while the run bit of its group is set
			always @(posedge sys_clk) begin
				if (osc_run[g] && tick_sync_q[g] && !tick_last_q[g]) begin
					osc_count_q[g] <= osc_count_q[g] + 1'b1;
				end
			end
		end
	endgenerate

	// ****************************************
	// oscillator control
	// ****************************************
	// ordinary read-write register, not limited to debug mode
	// both run bits are written together; bits 31:2 are reserved
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ring_osc_run_q <= `TSD_OSC_CONTROL_RST;
		end else if (ps_wr && ps_addr == `TSD_REG_OSC_CONTROL) begin
			ring_osc_run_q[`TSD_OSC_TILE_RUN_BIT]   <= ps_wdata[1];
			ring_osc_run_q[`TSD_OSC_PERIPH_RUN_BIT] <= ps_wdata[0];
		end
	end

	// ****************************************
	// debug capture and debug-writable fields
	// ****************************************
	// hardware capture on entry wins over a software write in the same cycle
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			saved_status_q   <= 32'h00000000;
			saved_pc_q       <= 32'h00000000;
			saved_sp_q       <= 32'h00000000;
			read_core_sel_q  <= 8'h00;
			read_reg_sel_q   <= 5'h00;
			cause_q          <= `TSD_CAUSE_RST;
			cause_index_q    <= 2'h0;
			cause_core_q     <= 8'h00;
			entry_data_q     <= 32'h00000000;
			core_stop_mask_q <= 8'h00;
		end else begin
			if (dbg_entry) begin
				saved_status_q <= saved_status_word;
				saved_pc_q     <= saved_program_counter;
				saved_sp_q     <= saved_stack_pointer;
				cause_q        <= dbg_entry_cause;
				cause_index_q  <= lowest_hit(dbg_entry_hits);
				cause_core_q   <= dbg_entry_core_valid ? dbg_entry_core : 8'h00;
				// other causes leave the last watch address for the debugger
				if (dbg_entry_cause == `TSD_CAUSE_DATA_WATCH ||
					dbg_entry_cause == `TSD_CAUSE_RES_WATCH) begin
					entry_data_q <= dbg_entry_data;
				end
			end else if (dbg_wr) begin
				case (ps_addr)
					`TSD_REG_SAVED_PC: begin
						saved_pc_q <= ps_wdata;
					end
					`TSD_REG_SAVED_SP: begin
						saved_sp_q <= ps_wdata;
					end
					`TSD_REG_ENTRY_CAUSE: begin
						// lets the debug handler clear or rewrite the cause
						cause_q       <= ps_wdata[2:0];
						cause_index_q <= ps_wdata[`TSD_CAUSE_INDEX_LSB +: 2];
						cause_core_q  <= ps_wdata[`TSD_CAUSE_CORE_LSB +: 8];
					end
					`TSD_REG_ENTRY_DATA: begin
						entry_data_q <= ps_wdata;
					end
					default: begin
					end
				endcase
			end
			// operands and mask are never touched by entry capture
			// a masked core stays stopped until its bit is cleared again
			if (dbg_wr && ps_addr == `TSD_REG_READ_CORE_SEL) begin
				read_core_sel_q <= ps_wdata[7:0];
			end
			if (dbg_wr && ps_addr == `TSD_REG_READ_REG_SEL) begin
				read_reg_sel_q <= ps_wdata[4:0];
			end
			if (dbg_wr && ps_addr == `TSD_REG_CORE_STOP_MASK) begin
				core_stop_mask_q <= ps_wdata[CORES-1:0];
			end
		end
	end

	// ****************************************
	// mailbox and breakpoint addresses
	// ****************************************
	// debug-mode writes only; the window test guards the low index bits
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (i = 0; i < 8; i = i + 1) begin
				mailbox_q[i] <= 32'h00000000;
			end
			for (i = 0; i < 4; i = i + 1) begin
				ibreak_addr_q[i] <= 32'h00000000;
			end
		end else if (dbg_wr) begin
			if (in_range(ps_addr, `TSD_REG_MAILBOX_BASE, `TSD_REG_MAILBOX_LAST)) begin
				mailbox_q[ps_addr[2:0]] <= ps_wdata;
			end
			if (in_range(ps_addr, `TSD_REG_IBREAK_BASE, `TSD_REG_IBREAK_LAST)) begin
				ibreak_addr_q[ps_addr[1:0]] <= ps_wdata;
			end
		end
	end

	// ****************************************
	// breakpoint comparators
	// ****************************************
	// one registered hit per address; there is no enable, every address is always compared
	// a hit needs a valid program counter in that same cycle
	generate
		for (g = 0; g < 4; g = g + 1) begin : ibrk
			always @(posedge sys_clk or negedge arst_n) begin
				if (!arst_n) begin
					ibreak_hit_q[g] <= 1'b0;
				end else begin
					ibreak_hit_q[g] <= pc_valid && (pc_value == ibreak_addr_q[g]);
				end
			end
		end
	endgenerate

	// ****************************************
	// read multiplexer
	// ****************************************
	// unmapped numbers and reserved bits read zero
	// decoded from the live address, so the answer holds the value at the read edge
	always @* begin
		rdata_d = 32'h00000000;
		case (ps_addr)
			`TSD_REG_BOOT_STATUS: begin
				rdata_d[`TSD_BOOT_TILE_NUM_LSB +: 8] = tile_number;
				rdata_d[`TSD_BOOT_OTP_EN_BIT] = otp_boot_en;
				rdata_d[7:0]   = boot_sync_q;
			end
			`TSD_REG_SECURITY_COPY: begin
				rdata_d = security_word;
			end
			`TSD_REG_OSC_CONTROL: begin
				rdata_d[1:0] = ring_osc_run_q;
			end
			`TSD_REG_SAVED_STATUS: begin
				rdata_d = saved_status_q;
			end
			`TSD_REG_SAVED_PC: begin
				rdata_d = saved_pc_q;
			end
			`TSD_REG_SAVED_SP: begin
				rdata_d = saved_sp_q;
			end
			`TSD_REG_READ_CORE_SEL: begin
				rdata_d[7:0] = read_core_sel_q;
			end
			`TSD_REG_READ_REG_SEL: begin
				rdata_d[4:0] = read_reg_sel_q;
			end
			`TSD_REG_ENTRY_CAUSE: begin
				rdata_d[`TSD_CAUSE_INDEX_LSB +: 2] = cause_index_q;
				rdata_d[`TSD_CAUSE_CORE_LSB +: 8]  = cause_core_q;
				rdata_d[2:0]   = cause_q;
			end
			`TSD_REG_ENTRY_DATA: begin
				rdata_d = entry_data_q;
			end
			`TSD_REG_CORE_STOP_MASK: begin
				rdata_d[CORES-1:0] = core_stop_mask_q;
			end
			default: begin
				if (in_range(ps_addr, `TSD_REG_OSC_COUNT_BASE, `TSD_REG_OSC_COUNT_LAST)) begin
					// count may tear if the oscillator still runs
					rdata_d[OSC_WIDTH-1:0] = osc_count_q[ps_addr[1:0] + 2'h1];
				end else if (in_range(ps_addr, `TSD_REG_MAILBOX_BASE,
					`TSD_REG_MAILBOX_LAST)) begin
					rdata_d = mailbox_q[ps_addr[2:0]];
				end else if (in_range(ps_addr, `TSD_REG_IBREAK_BASE,
					`TSD_REG_IBREAK_LAST)) begin
					rdata_d = ibreak_addr_q[ps_addr[1:0]];
				end
			end
		endcase
	end

	// ****************************************
	// read answer
	// ****************************************
	// answer one cycle after the read request, data held until the next read
	// rvalid is a one-cycle strobe; rdata stays for slower consumers
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ps_rdata_q  <= 32'h00000000;
			ps_rvalid_q <= 1'b0;
		end else begin
			ps_rvalid_q <= ps_rd;
			if (ps_rd) begin
				ps_rdata_q <= rdata_d;
			end
		end
	end

endmodule

// *** tb/tsd_status_regs_asserts.sv ***
`timescale 1ns/1ns
// ********
// status port checks
// ********
module tsd_status_regs_asserts (
	// clock and reset
	input logic        sys_clk,
	input logic        arst_n,
	// status bus
	input logic        ps_rd,
	input logic        ps_wr,
	input logic [7:0]  ps_addr,
	input logic [31:0] ps_wdata,
	input logic [31:0] ps_rdata_q,
	input logic        ps_rvalid_q,
	// sources and controls
	input logic [7:0]  tile_number,
	input logic        otp_boot_en,
	input logic [31:0] security_word,
	input logic [1:0]  ring_osc_run_q,
	input logic        debug_mode,
	input logic        dbg_entry,
	input logic [7:0]  core_stop_mask_q
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// accesses to single registers and to the count window
	wire wr_osc = ps_wr && ps_addr == 8'h06;
	wire wr_mask = ps_wr && ps_addr == 8'h18;
	wire rd_cnt = ps_rd && ps_addr >= 8'h07 && ps_addr <= 8'h0A;
	a_read_answer: assert property (ps_rd |=> ps_rvalid_q)
		else $error("read not answered");
	a_no_stray: assert property (!ps_rd |=> !ps_rvalid_q)
		else $error("answer without read");
	a_osc_write: assert property (wr_osc |=> ring_osc_run_q == $past(ps_wdata[1:0]))
		else $error("run bits differ from write");
	a_osc_hold: assert property (!wr_osc |=> $stable(ring_osc_run_q))
		else $error("run bits changed alone");
	a_mask_gate: assert property (wr_mask && !debug_mode |=> $stable(core_stop_mask_q))
		else $error("mask written outside debug");
	a_mask_write: assert property (wr_mask && debug_mode |=> core_stop_mask_q == $past(ps_wdata[7:0]))
		else $error("mask not written");
	a_boot_fields: assert property (ps_rd && ps_addr == 8'h03 |=>
		ps_rdata_q[31:8] == {8'h00, $past(tile_number), 7'h00, $past(otp_boot_en)})
		else $error("boot status fields wrong");
	a_sec_copy: assert property (ps_rd && ps_addr == 8'h05 |=> ps_rdata_q == $past(security_word))
		else $error("security copy wrong");
	a_count_upper: assert property (rd_cnt |=> ps_rdata_q[31:16] == 16'h0000)
		else $error("count upper half set");
	a_cause_resvd: assert property (ps_rd && ps_addr == 8'h15 |=>
		ps_rdata_q[31:18] == 14'h0000 && ps_rdata_q[7:3] == 5'h00)
		else $error("cause reserved bits set");
	// main scenarios reached
	c_entry: cover property (dbg_entry);
	c_mask: cover property (wr_mask && debug_mode);
	c_osc: cover property (wr_osc ##1 ps_rd);
endmodule

// *** tb/tsd_core_model.sv ***
`timescale 1ns/1ns
// core issuing status reads and writes by register number
module tsd_core_model (
	// clock and answer
	input logic         sys_clk,
	input logic [31:0]  ps_rdata_q,
	input logic         ps_rvalid_q,
	// requests
	output logic        ps_rd = 1'b0,
	output logic        ps_wr = 1'b0,
	output logic [7:0]  ps_addr = 8'h00,
	output logic [31:0] ps_wdata = 32'h00000000
);
	// one write; a released bus shows inverted values, not the old ones
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		ps_wr <= 1'b1;
		ps_addr <= a;
		ps_wdata <= d;
		@(posedge sys_clk);
		ps_wr <= 1'b0;
		ps_addr <= ~a;
		ps_wdata <= ~d;
	endtask
	// one read; a missing answer comes back unknown so it never matches
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		ps_rd <= 1'b1;
		ps_addr <= a;
		@(posedge sys_clk);
		ps_rd <= 1'b0;
		ps_addr <= ~a;
		#1;
		d = (ps_rvalid_q === 1'b1) ? ps_rdata_q : 32'hXXXXXXXX;
	endtask
endmodule

// *** tb/tsd_status_regs_tb_top.sv ***
`timescale 1ns/1ns
module tsd_status_regs_tb_top;
	// ********
	// stimulus and observed signals
	// ********
	logic sys_clk = 1'b0, arst_n = 1'b0, otp_boot_en = 1'b0, debug_mode = 1'b0;
	logic dbg_entry = 1'b0, dbg_entry_core_valid = 1'b0, pc_valid = 1'b0;
	logic ps_rd, ps_wr, ps_rvalid_q;
	logic [7:0] ps_addr, tile_number = 8'h00, boot_select_pins = 8'h00;
	logic [7:0] dbg_entry_core = 8'h00, core_stop_mask_q;
	logic [2:0] dbg_entry_cause = 3'h0;
	logic [3:0] dbg_entry_hits = 4'h0, ring_osc_tick = 4'h0, ibreak_hit_q;
	logic [1:0] ring_osc_run_q;
	logic [31:0] ps_wdata, ps_rdata_q, security_word = 32'h0, dbg_entry_data = 32'h0;
	logic [31:0] saved_status_word = 32'h0, saved_program_counter = 32'h0;
	logic [31:0] saved_stack_pointer = 32'h0, pc_value = 32'h0, d, e, dat_q;
	logic [31:0] brk [4];
	logic [15:0] exp_cnt [4];
	int fail_count = 0, n_compared = 0, cyc = 0, k, c;

	tsd_status_regs uut (.sys_clk, .arst_n, .ps_rd, .ps_wr, .ps_addr, .ps_wdata, .ps_rdata_q,
		.ps_rvalid_q, .tile_number, .otp_boot_en, .boot_select_pins, .security_word,
		.ring_osc_tick, .ring_osc_run_q, .debug_mode, .dbg_entry, .dbg_entry_cause,
		.dbg_entry_hits, .dbg_entry_core_valid, .dbg_entry_core, .dbg_entry_data,
		.saved_status_word, .saved_program_counter, .saved_stack_pointer,
		.core_stop_mask_q, .pc_valid, .pc_value, .ibreak_hit_q);
	tsd_core_model core (.sys_clk, .ps_rdata_q, .ps_rvalid_q, .ps_rd, .ps_wr, .ps_addr, .ps_wdata);

	// clock and hang limit; a run needs only a few hundred cycles
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			finish_test();
		end
	end

	task automatic chk(input logic [31:0] got, exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic wr_rd(input logic [7:0] a, input logic [31:0] v, m);
		logic [31:0] r;
		core.wr(a, v);
		core.rd(a, r);
		chk(r, v & m, "write then read");
	endtask
	// lowest hit wins when several trigger together
	function automatic logic [1:0] low_idx(input logic [3:0] h);
		low_idx = h[0] ? 2'h0 : h[1] ? 2'h1 : h[2] ? 2'h2 : h[3] ? 2'h3 : 2'h0;
	endfunction
	// random ticks for 20 cycles, then idle long enough to drain the synchroniser
	task automatic tick_burst(input logic [1:0] run);
		logic [31:0] r;
		logic [3:0] p;
		int j;
		p = 4'h0;
		repeat (20) begin
			@(posedge sys_clk);
			r = $urandom;
			ring_osc_tick <= r[3:0];
			for (j = 0; j < 4; j++)
				if (r[j] && !p[j] && run[j < 2 ? 1 : 0])
					exp_cnt[j]++;
			p = r[3:0];
		end
		@(posedge sys_clk);
		ring_osc_tick <= 4'h0;
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// main sequence
	initial begin
		e = $urandom(6);
		// counts have no reset; give them a known start so deltas can be checked
		for (k = 0; k < 4; k++) begin
			uut.osc_count_q[k] = 16'h0000;
			exp_cnt[k] = 16'h0000;
		end
		repeat (10) @(posedge sys_clk);
		arst_n <= 1'b1;
		core.rd(8'h06, d);
		chk(d, 32'h0, "osc control reset");
		core.rd(8'h15, d);
		chk(d, 32'h0, "cause reset");
		core.rd(8'h04, d);
		chk(d, 32'h0, "unmapped read");
		@(posedge sys_clk);
		e = $urandom;
		tile_number <= e[7:0];
		otp_boot_en <= e[8];
		boot_select_pins <= e[23:16];
		security_word <= $urandom;
		repeat (3) @(posedge sys_clk);
		core.rd(8'h03, d);
		chk(d, {8'h00, tile_number, 7'h00, otp_boot_en, boot_select_pins}, "boot");
		core.rd(8'h05, d);
		chk(d, security_word, "security copy");
		core.wr(8'h06, 32'hFFFFFFFF);
		#1;
		chk({30'h0, ring_osc_run_q}, 32'h3, "run outputs");
		core.rd(8'h06, d);
		chk(d, 32'h3, "osc control");
		tick_burst(2'h3);
		core.wr(8'h06, 32'h1);
		tick_burst(2'h1);
		core.wr(8'h06, 32'h0);
		tick_burst(2'h0);
		// counts must survive a reset taken after the oscillators are stopped
		for (c = 0; c < 2; c++) begin
			for (k = 7; k <= 10; k++) begin
				core.rd(k[7:0], d);
				chk(d, {16'h0000, exp_cnt[k - 7]}, "osc count");
			end
			@(posedge sys_clk);
			arst_n <= 1'b0;
			repeat (2) @(posedge sys_clk);
			arst_n <= 1'b1;
		end
		core.rd(8'h06, d);
		chk(d, 32'h0, "osc control after reset");
		wr_rd(8'h18, 32'hFF, 32'h0);
		wr_rd(8'h20, $urandom, 32'h0);
		@(posedge sys_clk);
		debug_mode <= 1'b1;
		wr_rd(8'h13, $urandom, 32'hFF);
		wr_rd(8'h14, $urandom, 32'h1F);
		wr_rd(8'h18, $urandom, 32'hFF);
		for (k = 0; k < 8; k++)
			wr_rd(8'h20 + k[7:0], $urandom, 32'hFFFFFFFF);
		for (k = 0; k < 4; k++) begin
			brk[k] = ($urandom & 32'hFFFFFFFC) | k;
			wr_rd(8'h30 + k[7:0], brk[k], 32'hFFFFFFFF);
		end
		for (k = 0; k < 4; k++) begin
			@(posedge sys_clk);
			pc_valid <= 1'b1;
			pc_value <= brk[k];
			@(posedge sys_clk);
			pc_valid <= 1'b0;
			pc_value <= ~brk[k];
			#1;
			chk({28'h0, ibreak_hit_q}, {28'h0, 4'h1 << k}, "breakpoint hit");
		end
		dat_q = 32'h0;
		for (c = 1; c <= 5; c++) begin
			@(posedge sys_clk);
			e = $urandom;
			dbg_entry <= 1'b1;
			dbg_entry_cause <= c[2:0];
			dbg_entry_hits <= (c > 2) ? e[3:0] : 4'h0;
			dbg_entry_core_valid <= e[4];
			dbg_entry_core <= e[15:8];
			dbg_entry_data <= $urandom;
			saved_status_word <= $urandom;
			saved_program_counter <= $urandom;
			saved_stack_pointer <= $urandom;
			@(posedge sys_clk);
			dbg_entry <= 1'b0;
			if (c > 3)
				dat_q = dbg_entry_data;
			core.rd(8'h15, d);
			chk(d, {14'h0, low_idx(dbg_entry_hits), dbg_entry_core_valid ? dbg_entry_core : 8'h00,
				5'h0, dbg_entry_cause}, "cause word");
			core.rd(8'h16, d);
			chk(d, dat_q, "entry data");
			core.rd(8'h11, d);
			chk(d, saved_program_counter, "saved pc");
			core.rd(8'h12, d);
			chk(d, saved_stack_pointer, "saved sp");
		end
		core.wr(8'h10, ~saved_status_word);
		core.rd(8'h10, d);
		chk(d, saved_status_word, "saved status");
		finish_test();
	end
endmodule

bind tsd_status_regs tsd_status_regs_asserts u_chk (.sys_clk, .arst_n, .ps_rd, .ps_wr, .ps_addr,
	.ps_wdata, .ps_rdata_q, .ps_rvalid_q, .tile_number, .otp_boot_en, .security_word,
	.ring_osc_run_q, .debug_mode, .dbg_entry, .core_stop_mask_q);
